// ### hdl/jump_branch_bit_control_decode.v
// sequencer for jump, branch, bit-manipulation and control instructions
// assumes a synchronous byte memory: read data valid on the internal cycle
// after MEM_ADDR was presented with MEM_RD; other opcodes flagged on OTHER_OP
`timescale 1ns/10ps
`include "jbb_consts.vh"
module jump_branch_bit_control_decode (
  // clock and reset
  input wire MCLK,
  input wire ARST_N,
  // memory bus
  output reg [15:0] MEM_ADDR,
  output reg MEM_RD,
  output reg MEM_WR,
  output reg [7:0] MEM_WDATA,
  input wire [7:0] MEM_RDATA,
  // core state shared with the rest of the cpu
  input wire [7:0] ACC_IN,
  input wire IRQ_LINE,
  output reg [15:0] PC,
  output reg [7:0] INDEX_X,
  output reg [7:0] ACC_OUT,
  output reg ACC_LOAD,
  output reg [4:0] CONDITION_FLAGS,
  output reg [7:0] STACK_PTR,
  output reg OTHER_OP,
  output reg HALTED
);
  // sequencer states; each except S_HALT holds for one internal cycle
  localparam S_FETCH = 4'h0;
  localparam S_DECODE = 4'h1;
  localparam S_OPR1 = 4'h2;
  localparam S_OPR2 = 4'h3;
  localparam S_OPR3 = 4'h4;
  localparam S_BITREAD = 4'h5;
  localparam S_BITWR = 4'h6;
  localparam S_PUSHLO = 4'h7;
  localparam S_PUSHHI = 4'h8;
  localparam S_HALT = 4'h9;
  localparam S_EXEC = 4'ha;

  wire tick;
  reg [3:0] state_reg;
  reg [7:0] opcode_reg;
  reg [7:0] byte1_reg;
  reg [7:0] byte2_reg;
  reg [15:0] target_reg;
  reg [15:0] ret_reg;
  // fields decoded from the opcode and the captured operand bytes
  wire [3:0] row = opcode_reg[7:4];
  wire [3:0] col = opcode_reg[3:0];
  wire [2:0] bit_sel = opcode_reg[3:1];
  wire bit_sense_clear = opcode_reg[0];
  wire [7:0] bit_mask = 8'h01 << bit_sel;
  wire [15:0] rel3_ofs = {{8{byte2_reg[7]}}, byte2_reg};
  wire is_jump = (row >= `ROW_JUMP_DIR) && ((col == `LO_JUMP) || (col == `LO_JSR));
  reg cond_true;

  // internal cycle = two oscillator cycles
  phase_divider #(
    .PER(`OSC_PER_INTERNAL)
  ) u_div (
    .clk(MCLK),
    .arst_n(ARST_N),
    .tick_reg(tick)
  );

  // branch condition from the low nibble; odd codes invert the even test
  always @*
  begin
    case (col[3:1])
      3'h0: cond_true = 1'b1;
      3'h1: cond_true = ~(CONDITION_FLAGS[`FLAG_C] | CONDITION_FLAGS[`FLAG_Z]);
      3'h2: cond_true = ~CONDITION_FLAGS[`FLAG_C];
      3'h3: cond_true = ~CONDITION_FLAGS[`FLAG_Z];
      3'h4: cond_true = ~CONDITION_FLAGS[`FLAG_H];
      3'h5: cond_true = ~CONDITION_FLAGS[`FLAG_N];
      3'h6: cond_true = ~CONDITION_FLAGS[`FLAG_I];
      3'h7: cond_true = IRQ_LINE;
      default: cond_true = 1'b0;
    endcase
    if (col[0])
      cond_true = ~cond_true;
  end

  // main sequencer, advancing once per internal cycle
  always @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_reg <= S_FETCH;
      opcode_reg <= 8'h00;
      byte1_reg <= 8'h00;
      byte2_reg <= 8'h00;
      target_reg <= 16'h0000;
      ret_reg <= 16'h0000;
      PC <= `PC_RESET;
      INDEX_X <= 8'h00;
      ACC_OUT <= 8'h00;
      ACC_LOAD <= 1'b0;
      CONDITION_FLAGS <= `FLAGS_RESET;
      STACK_PTR <= `SP_RESET;
      MEM_ADDR <= 16'h0000;
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      MEM_WDATA <= 8'h00;
      OTHER_OP <= 1'b0;
      HALTED <= 1'b0;
    end
    else if (tick)
    begin
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      ACC_LOAD <= 1'b0;
      OTHER_OP <= 1'b0;
      case (state_reg)
        S_FETCH:
        begin
          MEM_ADDR <= PC;
          MEM_RD <= 1'b1;
          PC <= PC + 16'h0001;
          state_reg <= S_DECODE;
        end
        S_DECODE:
        begin
          opcode_reg <= MEM_RDATA;
          // indexed no-offset jumps and control opcodes carry no stream byte
          if ((MEM_RDATA[7:4] <= `ROW_BRANCH) || (MEM_RDATA == `OP_BSR) ||
              ((MEM_RDATA[7:4] >= `ROW_JUMP_DIR) && (MEM_RDATA[7:4] != `ROW_JUMP_IX) &&
               ((MEM_RDATA[3:0] == `LO_JUMP) || (MEM_RDATA[3:0] == `LO_JSR))))
          begin
            // every such opcode carries at least one stream byte
            MEM_ADDR <= PC;
            MEM_RD <= 1'b1;
            PC <= PC + 16'h0001;
            state_reg <= S_OPR1;
          end
          else
            state_reg <= S_EXEC;
        end
        S_OPR1:
        begin
          byte1_reg <= MEM_RDATA;
          if (row == `ROW_BITBRANCH)
          begin
            MEM_ADDR <= PC; // third byte: signed offset
            MEM_RD <= 1'b1;
            PC <= PC + 16'h0001;
            state_reg <= S_OPR2;
          end
          else if (row == `ROW_BITSETCLR)
          begin
            MEM_ADDR <= {8'h00, MEM_RDATA};
            MEM_RD <= 1'b1;
            state_reg <= S_BITREAD;
          end
          else if ((row == `ROW_JUMP_EXT) || (row == `ROW_JUMP_IX2))
          begin
            MEM_ADDR <= PC; // high byte came first, fetch low
            MEM_RD <= 1'b1;
            PC <= PC + 16'h0001;
            state_reg <= S_OPR3;
          end
          else
          begin
            // one-byte operand: relative, direct or 8-bit indexed
            if (row == `ROW_BRANCH || opcode_reg == `OP_BSR)
              target_reg <= PC + {{8{MEM_RDATA[7]}}, MEM_RDATA};
            else if (row == `ROW_JUMP_DIR)
              target_reg <= {8'h00, MEM_RDATA};
            else
              target_reg <= {8'h00, MEM_RDATA} + {8'h00, INDEX_X};
            state_reg <= S_EXEC;
          end
        end
        S_OPR2:
        begin
          byte2_reg <= MEM_RDATA;
          MEM_ADDR <= {8'h00, byte1_reg};
          MEM_RD <= 1'b1;
          state_reg <= S_BITREAD;
        end
        S_OPR3:
        begin
          // the high byte was kept from the previous operand fetch
          if (row == `ROW_JUMP_EXT)
            target_reg <= {byte1_reg, MEM_RDATA};
          else
            target_reg <= {byte1_reg, MEM_RDATA} + {8'h00, INDEX_X};
          state_reg <= S_EXEC;
        end
        S_BITREAD:
        begin
          if (row == `ROW_BITBRANCH)
          begin
            // carry follows the tested bit whether or not the branch is taken
            CONDITION_FLAGS[`FLAG_C] <= MEM_RDATA[bit_sel];
            if (MEM_RDATA[bit_sel] != bit_sense_clear)
              PC <= PC + rel3_ofs;
            state_reg <= S_FETCH;
          end
          else
          begin
            // whole byte goes back: a port bit that reads unlike its latch is copied
            MEM_WDATA <= bit_sense_clear ? (MEM_RDATA & ~bit_mask)
                                         : (MEM_RDATA | bit_mask);
            MEM_WR <= 1'b1;
            state_reg <= S_BITWR;
          end
        end
        S_BITWR:
          state_reg <= S_FETCH;
        S_PUSHLO:
        begin
          // second push: return high byte, then the target goes to pc
          MEM_ADDR <= {8'h00, STACK_PTR};
          MEM_WDATA <= ret_reg[15:8];
          MEM_WR <= 1'b1;
          STACK_PTR <= STACK_PTR - 8'h01;
          PC <= target_reg;
          state_reg <= S_FETCH;
        end
        S_HALT:
        begin
          HALTED <= 1'b1; // left only by reset
          state_reg <= S_HALT;
        end
        S_EXEC:
        begin
          state_reg <= S_FETCH;
          // a ROW_BRANCH target reaches pc only here, so an untaken branch keeps the sequential pc
          if (row == `ROW_BRANCH)
          begin
            if (cond_true)
              PC <= target_reg;
          end
          else if (is_jump && (col == `LO_JUMP))
          begin
            if (row == `ROW_JUMP_IX)
              PC <= {8'h00, INDEX_X};
            else
              PC <= target_reg;
          end
          else if ((is_jump && (col == `LO_JSR)) || (opcode_reg == `OP_BSR))
          begin
            // low byte first so the high byte sits above it on the stack
            ret_reg <= PC;
            MEM_ADDR <= {8'h00, STACK_PTR};
            MEM_WDATA <= PC[7:0];
            MEM_WR <= 1'b1;
            STACK_PTR <= STACK_PTR - 8'h01;
            if (row == `ROW_JUMP_IX)
              target_reg <= {8'h00, INDEX_X};
            state_reg <= S_PUSHLO;
          end
          else
          begin
            // inherent control set, no operand bytes consumed
            case (opcode_reg)
              `OP_TAX: INDEX_X <= ACC_IN;
              `OP_TXA:
              begin
                ACC_OUT <= INDEX_X;
                ACC_LOAD <= 1'b1;
              end
              `OP_SEC: CONDITION_FLAGS[`FLAG_C] <= 1'b1;
              `OP_CLC: CONDITION_FLAGS[`FLAG_C] <= 1'b0;
              `OP_SEI: CONDITION_FLAGS[`FLAG_I] <= 1'b1;
              `OP_CLI: CONDITION_FLAGS[`FLAG_I] <= 1'b0;
              `OP_RSP: STACK_PTR <= `SP_RESET;
              `OP_NOP: state_reg <= S_FETCH;
              `OP_STOP: state_reg <= S_HALT;
              `OP_WAIT: state_reg <= S_HALT;
              default: OTHER_OP <= 1'b1; // swi, returns and others handled elsewhere
            endcase
          end
        end
        default: state_reg <= S_FETCH;
      endcase
    end
  end
endmodule

// ### hdl/jbb_consts.vh
// constants for the jump, branch, bit and control sequencer
// assumes inclusion by bare name from the design files
`ifndef JBB_CONSTS_VH
`define JBB_CONSTS_VH
// opcode row (high nibble) classes
`define ROW_BITBRANCH 4'h0
`define ROW_BITSETCLR 4'h1
`define ROW_BRANCH 4'h2
`define ROW_JUMP_DIR 4'hb
`define ROW_JUMP_EXT 4'hc
`define ROW_JUMP_IX2 4'hd
`define ROW_JUMP_IX1 4'he
`define ROW_JUMP_IX 4'hf
`define ROW_CTRL_A 4'h8
`define ROW_CTRL_B 4'h9
// low nibble of jump rows
`define LO_JUMP 4'hc
`define LO_JSR 4'hd
// fixed opcodes
`define OP_BSR 8'had
`define OP_SWI 8'h83
`define OP_RTI 8'h80
`define OP_RTS 8'h81
`define OP_WAIT 8'h8f
`define OP_STOP 8'h8e
`define OP_TAX 8'h97
`define OP_TXA 8'h9f
`define OP_SEC 8'h99
`define OP_CLC 8'h98
`define OP_SEI 8'h9b
`define OP_CLI 8'h9a
`define OP_RSP 8'h9c
`define OP_NOP 8'h9d
// condition flag bit positions
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_I 3
`define FLAG_H 4
// reset values
`define PC_RESET 16'h0000
`define SP_RESET 8'hff
`define FLAGS_RESET 5'h08
// timing: oscillator cycles per internal cycle
`define OSC_PER_INTERNAL 2
`endif

// ### hdl/phase_divider.v
// internal cycle divider: one strobe every PER oscillator clocks
// assumes MCLK is the oscillator input and reset is asynchronous low
`timescale 1ns/10ps
module phase_divider #(
  parameter PER = 2
) (
  input wire clk,
  input wire arst_n,
  output reg tick_reg
);
  reg [3:0] count_reg;
  // the whole core advances only on tick, so one step spans PER clocks
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_reg <= 4'h0;
      tick_reg <= 1'b0;
    end
    else if (count_reg == PER[3:0] - 4'h1)
    begin
      count_reg <= 4'h0;
      tick_reg <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 4'h1;
      tick_reg <= 1'b0;
    end
  end
endmodule

// ### tb/jbb_mem_model.sv
// byte memory standing for ram and registers on the internal bus
// assumes strobes stand two clocks, so data is ready by the next tick
`timescale 1ns/10ps
module jbb_mem_model (
  // clock
  input wire clk,
  // bus from the sequencer
  input wire [15:0] addr,
  input wire rd,
  input wire wr,
  input wire [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:65535];
  // an idle bus shows the inverse, so stale data never passes for an answer
  always @(posedge clk)
  begin
    if (wr)
      mem[addr] <= wdata;
    rdata <= rd ? mem[addr] : ~rdata;
  end
endmodule

// ### tb/jbb_chk.sv
// checker for memory strobes, halt state and flag side effects
// assumes binding onto the sequencer top; sees only its ports
`timescale 1ns/10ps
module jbb_chk (
  // clock and reset
  input wire MCLK,
  input wire ARST_N,
  // memory bus
  input wire [15:0] MEM_ADDR,
  input wire MEM_RD,
  input wire MEM_WR,
  input wire [7:0] MEM_WDATA,
  // core state
  input wire [7:0] ACC_IN,
  input wire [7:0] INDEX_X,
  input wire [7:0] ACC_OUT,
  input wire ACC_LOAD,
  input wire [4:0] CONDITION_FLAGS,
  input wire HALTED
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  // bus moves once per internal cycle of two clocks
  AST_RD_HOLD: assert property ($rose(MEM_RD) |=> MEM_RD)
    else $error("read strobe shorter than two clocks");
  AST_ADDR_HOLD: assert property ($changed(MEM_ADDR) |=> $stable(MEM_ADDR))
    else $error("address held less than two clocks");
  AST_WR_HOLD: assert property ($rose(MEM_WR) |=> MEM_WR && $stable(MEM_WDATA))
    else $error("write not held two clocks");
  // bit writes and pushes only reach the first page
  AST_WR_PAGE0: assert property (MEM_WR |-> MEM_ADDR[15:8] == 8'h00)
    else $error("write outside first page");
  AST_HALT_STICKY: assert property (HALTED |=> HALTED)
    else $error("halt left without reset");
  AST_HALT_QUIET: assert property (HALTED [*3] |-> !MEM_RD && !MEM_WR)
    else $error("bus active while halted");
  AST_TAX: assert property ($changed(INDEX_X) |-> INDEX_X == ACC_IN)
    else $error("index loaded from other than accumulator");
  AST_TXA: assert property (ACC_LOAD |-> ACC_OUT == INDEX_X)
    else $error("accumulator load not from index");
  // these opcodes touch only carry and mask
  AST_FLAGS_KEEP: assert property ($stable({CONDITION_FLAGS[4], CONDITION_FLAGS[2:1]}))
    else $error("h n z flags changed");
endmodule
bind jump_branch_bit_control_decode jbb_chk u_chk (.MCLK, .ARST_N, .MEM_ADDR, .MEM_RD,
  .MEM_WR, .MEM_WDATA, .ACC_IN, .INDEX_X, .ACC_OUT, .ACC_LOAD, .CONDITION_FLAGS, .HALTED);

// ### tb/jump_branch_bit_control_decode_tb_top.sv
// bench: one instruction row at address 0, test byte 05 at 0040, stop opcode everywhere else
// assumes the memory model answers one internal cycle after each strobe
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module jump_branch_bit_control_decode_tb_top;
  typedef struct packed {logic [31:0] code; logic [15:0] pc; logic c; logic [15:0] ma;
    logic [7:0] mv;} row_t;
  localparam int N = 30;
  // code bytes, stop fetch address, carry, memory byte to check
  row_t rows [0:N-1] = '{
    '{32'h20108e8e, 16'h0012, 1'b0, 16'h0040, 8'h05},
    '{32'h21108e8e, 16'h0002, 1'b0, 16'h0040, 8'h05},
    '{32'h20808e8e, 16'hff82, 1'b0, 16'h0040, 8'h05},
    '{32'h207f8e8e, 16'h0081, 1'b0, 16'h0040, 8'h05},
    '{32'h0040108e, 16'h0013, 1'b1, 16'h0040, 8'h05},
    '{32'h0140108e, 16'h0003, 1'b1, 16'h0040, 8'h05},
    '{32'h02407f8e, 16'h0003, 1'b0, 16'h0040, 8'h05},
    '{32'h03407f8e, 16'h0082, 1'b0, 16'h0040, 8'h05},
    '{32'h25108e8e, 16'h0002, 1'b0, 16'h0040, 8'h05},
    '{32'h24f08e8e, 16'hfff2, 1'b0, 16'h0040, 8'h05},
    '{32'hcc12348e, 16'h1234, 1'b0, 16'h0040, 8'h05},
    '{32'hbc568e8e, 16'h0056, 1'b0, 16'h0040, 8'h05},
    '{32'h97ec308e, 16'h0035, 1'b0, 16'h0040, 8'h05},
    '{32'h97fc8e8e, 16'h0005, 1'b0, 16'h0040, 8'h05},
    '{32'h97dc1200, 16'h1205, 1'b0, 16'h0040, 8'h05},
    '{32'h12408e8e, 16'h0002, 1'b0, 16'h0040, 8'h07},
    '{32'h15408e8e, 16'h0002, 1'b0, 16'h0040, 8'h01},
    '{32'hcd12348e, 16'h1234, 1'b0, 16'h00ff, 8'h03},
    '{32'had108e8e, 16'h0012, 1'b0, 16'h00ff, 8'h02},
    '{32'h9925108e, 16'h0013, 1'b1, 16'h0040, 8'h05},
    '{32'h9824108e, 16'h0013, 1'b0, 16'h0040, 8'h05},
    '{32'h22108e8e, 16'h0012, 1'b0, 16'h0040, 8'h05},
    '{32'h27108e8e, 16'h0002, 1'b0, 16'h0040, 8'h05},
    '{32'h2c108e8e, 16'h0002, 1'b0, 16'h0040, 8'h05},
    '{32'h9a2c108e, 16'h0013, 1'b0, 16'h0040, 8'h05},
    '{32'h9a9b2d10, 16'h0014, 1'b0, 16'h0040, 8'h05},
    '{32'h29108e8e, 16'h0002, 1'b0, 16'h0040, 8'h05},
    '{32'h2a108e8e, 16'h0012, 1'b0, 16'h0040, 8'h05},
    '{32'h0e40108e, 16'h0003, 1'b0, 16'h0040, 8'h05},
    '{32'h1e408e8e, 16'h0002, 1'b0, 16'h0040, 8'h85}};
  logic MCLK;
  logic ARST_N = 1'b0;
  logic [7:0] ACC_IN = 8'h05;
  logic IRQ_LINE = 1'b0;
  wire [15:0] MEM_ADDR, PC;
  wire [7:0] MEM_WDATA, MEM_RDATA, INDEX_X, ACC_OUT, STACK_PTR;
  wire [4:0] CONDITION_FLAGS;
  wire MEM_RD, MEM_WR, ACC_LOAD, OTHER_OP, HALTED;
  int err_count = 0;
  int tests_run = 0;
  logic [15:0] last_rd;
  logic [1:0] seen;
  jump_branch_bit_control_decode u_dut (.MCLK(MCLK), .ARST_N(ARST_N), .MEM_ADDR(MEM_ADDR),
    .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
    .ACC_IN(ACC_IN), .IRQ_LINE(IRQ_LINE), .PC(PC), .INDEX_X(INDEX_X), .ACC_OUT(ACC_OUT),
    .ACC_LOAD(ACC_LOAD), .CONDITION_FLAGS(CONDITION_FLAGS), .STACK_PTR(STACK_PTR),
    .OTHER_OP(OTHER_OP), .HALTED(HALTED));
  jbb_mem_model u_mem (.clk(MCLK), .addr(MEM_ADDR), .rd(MEM_RD), .wr(MEM_WR),
    .wdata(MEM_WDATA), .rdata(MEM_RDATA));
  initial
  begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  // the stop opcode fetch is the last read before halting
  always @(posedge MCLK)
    if (MEM_RD === 1'b1)
      last_rd <= MEM_ADDR;
  // sticky marks for the one-tick pulses, cleared while reset is held
  always @(posedge MCLK)
    if (ARST_N !== 1'b1)
      seen <= 2'b00;
    else
      seen <= seen | {ACC_LOAD === 1'b1, OTHER_OP === 1'b1};
  task close_out;
  begin
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  // load a row under reset, release, run until halted
  task run_code(input logic [31:0] code);
  begin
    ARST_N = 1'b0;
    {u_mem.mem[0], u_mem.mem[1], u_mem.mem[2], u_mem.mem[3]} = code;
    u_mem.mem[16'h0040] = 8'h05;
    u_mem.mem[16'h00fe] = 8'h8e;
    u_mem.mem[16'h00ff] = 8'h8e;
    repeat (5) @(posedge MCLK);
    #1;
    `CHK({PC, STACK_PTR, CONDITION_FLAGS, HALTED}, {16'h0000, 8'hff, 5'h08, 1'b0})
    ARST_N = 1'b1;
    for (int k = 0; k < 300 && HALTED !== 1'b1; k++)
    begin
      @(posedge MCLK);
      #1;
    end
    repeat (2) @(posedge MCLK);
    #1;
  end
  endtask
  initial
  begin
    for (int a = 0; a < 65536; a++) u_mem.mem[a] = 8'h8e;
    @(posedge MCLK);
    #1;
    for (int i = 0; i < N; i++)
    begin
      run_code(rows[i].code);
      `CHK(HALTED, 1'b1)
      `CHK(last_rd, rows[i].pc)
      `CHK(PC, rows[i].pc + 16'h0001)
      `CHK(CONDITION_FLAGS[0], rows[i].c)
      `CHK(u_mem.mem[rows[i].ma], rows[i].mv)
      $display("row %0d done", i);
    end
    // inherent transfers plus an opcode left to the rest of the core
    run_code(32'h979f418e);
    `CHK({INDEX_X, ACC_OUT, seen}, {8'h05, 8'h05, 2'b11})
    `CHK(last_rd, 16'h0003)
    // subroutine branch lands on a stack reset: pointer back at the top
    u_mem.mem[16'h0012] = 8'h9c;
    run_code(32'had108e8e);
    `CHK({STACK_PTR, last_rd}, {8'hff, 16'h0013})
    u_mem.mem[16'h0012] = 8'h8e;
    $display("control and stack done");
    // reset in mid subroutine call, then rerun it whole
    run_code(32'hcd12348e);
    ARST_N = 1'b0;
    #1;
    `CHK({HALTED, PC, STACK_PTR}, {1'b0, 16'h0000, 8'hff})
    @(posedge MCLK);
    #1 ARST_N = 1'b1;
    // first two edges after release: divider still warming, bus idle
    repeat (2) @(posedge MCLK);
    #1;
    `CHK({MEM_RD, PC}, {1'b0, 16'h0000})
    @(posedge MCLK);
    #1;
    `CHK({MEM_RD, MEM_ADDR, PC}, {1'b1, 16'h0000, 16'h0001})
    // eight more edges reach the first push of the return address
    repeat (8) @(posedge MCLK);
    #1;
    `CHK({MEM_WR, MEM_ADDR, MEM_WDATA}, {1'b1, 16'h00ff, 8'h03})
    ARST_N = 1'b0;
    #1;
    `CHK({MEM_WR, PC, STACK_PTR}, {1'b0, 16'h0000, 8'hff})
    @(posedge MCLK);
    #1;
    run_code(32'hcd12348e);
    `CHK({last_rd, u_mem.mem[16'h00fe], u_mem.mem[16'h00ff]}, {16'h1234, 8'h00, 8'h03})
    $display("mid-run reset done");
    close_out;
  end
  // hang guard, well above the fewer than a thousand clocks the tests need
  initial
  begin
    #200000;
    err_count++;
    close_out;
  end
endmodule
